// ===== rtl/hicd_top.sv
// Serial command decoder of the haptic controller
`timescale 1ns/1ns
`default_nettype none
`include "hicd_regs.svh"
// Overview of operation
// - SDA rising while SCL high is a Stop ending the transfer.
// - A Stop returns the serial interface to idle, ready for Start.
// - Unexpected Start or Stop mid-transfer aborts without any effect.
// - First byte holds address 0010000 plus direction; only a match answers.
// - Command is two bytes, second the two's complement of the first.
// - Codes 0x00 to 0x0D select one of fourteen effects.
// - An effect starts only after a valid command and its Stop.
// - Pair 0x0F 0xF1 stops the playing effect at Stop.
// - Pair 0x0E 0xF2 readies revision bytes for a read after a repeated Start.
// - Restart or Stop in a data bit abandons, leaving state unchanged.
// - A pair failing the complement check is discarded.
// - Revision goes out most significant byte first, advancing per byte.
// - Undefined command releases SDA and ignores the bus until new Start.
// - General call or foreign address gets no acknowledge.
// - Ten-bit address sequences never address this device.
module hicd_top #(
    parameter int                   REV_BYTES = 2,
    parameter logic [8*REV_BYTES-1:0] REV_DATA  = '0
) (
    // Clocks and reset
    input  wire logic i_ref_clk,
    input  wire logic i_bus_clk,
    input  wire logic i_rstn,
    // Serial bus pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe,
    // Effect engine side
    input  wire logic i_effect_done,
    output logic      o_effect_start,
    output logic      o_effect_abort,
    output logic [3:0] o_effect_index,
    output logic      o_playing
);
    if (REV_BYTES < 1 || REV_BYTES > 255)
    begin : g_chk
        $error("REV_BYTES must lie in 1..255");
    end

    logic [1:0]               pins_s;
    logic                     scl_s;
    logic                     sda_s;
    logic                     scl_d_reg;
    logic                     sda_d_reg;
    hicd_pkg::hicd_state_type state_reg,   state_next;
    hicd_pkg::hicd_kind_type  kind_reg,    kind_next;
    logic [3:0]               bitcnt_reg,  bitcnt_next;
    logic [7:0]               shreg_reg,   shreg_next;
    logic [7:0]               txreg_reg,   txreg_next;
    logic [7:0]               cmd0_reg,    cmd0_next;
    logic [7:0]               rd_idx_reg,  rd_idx_next;
    logic                     wr_ok_reg,   wr_ok_next;
    logic                     rev_rdy_reg, rev_rdy_next;
    logic                     oe_reg,      oe_next;
    logic                     tog_reg,     tog_next;
    hicd_pkg::hicd_cmd_type   cmd_reg,     cmd_next;
    logic                     start_c;
    logic                     stop_c;
    logic                     rise_c;
    logic                     fall_c;
    logic [7:0]               cur_byte;
    logic                     evt_pulse;

    hicd_sync #(
        .WIDTH (`HICD_SYNC_STAGES)
    ) u_pin_sync (
        .i_clk   (i_bus_clk),
        .i_rstn  (i_rstn),
        .i_async ({i_scl, i_sda}),
        .o_sync  (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    function automatic logic [7:0] rev_byte(input logic [7:0] idx);
        logic [8*REV_BYTES-1:0] sh;
        sh = REV_DATA << {idx, 3'h0};
        if (idx < 8'(REV_BYTES))
            rev_byte = sh[8*REV_BYTES-1 -: 8];
        else
            rev_byte = `HICD_FILL_BYTE;
    endfunction

    always_comb
    begin
        start_c  = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        stop_c   = scl_s && scl_d_reg && !sda_d_reg && sda_s;
        rise_c   = scl_s && !scl_d_reg;
        fall_c   = !scl_s && scl_d_reg;
        cur_byte = rev_byte(rd_idx_reg);
    end

    // Bus-side sequencer
    always_comb
    begin
        state_next   = state_reg;
        kind_next    = kind_reg;
        bitcnt_next  = bitcnt_reg;
        shreg_next   = shreg_reg;
        txreg_next   = txreg_reg;
        cmd0_next    = cmd0_reg;
        rd_idx_next  = rd_idx_reg;
        wr_ok_next   = wr_ok_reg;
        rev_rdy_next = rev_rdy_reg;
        oe_next      = oe_reg;
        tog_next     = tog_reg;
        cmd_next     = cmd_reg;
        if (start_c)
        begin
            // Restart keeps only a completed revision request
            rev_rdy_next = (state_reg == hicd_pkg::ST_WAIT_P) && wr_ok_reg
                           && (cmd0_reg == `HICD_CMD_REV);
            state_next   = hicd_pkg::ST_RX;
            kind_next    = hicd_pkg::K_ADDR;
            bitcnt_next  = 4'h0;
            oe_next      = 1'b0;
            wr_ok_next   = 1'b0;
            rd_idx_next  = 8'h00;
        end
        else if (stop_c)
        begin
            if (state_reg == hicd_pkg::ST_WAIT_P && wr_ok_reg
                && cmd0_reg != `HICD_CMD_REV)
            begin
                tog_next       = !tog_reg;
                cmd_next.abort = (cmd0_reg == `HICD_CMD_ABORT);
                cmd_next.index = cmd0_reg[3:0];
            end
            state_next   = hicd_pkg::ST_IDLE;
            oe_next      = 1'b0;
            wr_ok_next   = 1'b0;
            rev_rdy_next = 1'b0;
        end
        else if (rise_c)
        begin
            case (state_reg)
                hicd_pkg::ST_RX:
                begin
                    shreg_next  = {shreg_reg[6:0], sda_s};
                    bitcnt_next = bitcnt_reg + 4'h1;
                end
                hicd_pkg::ST_MACK:
                begin
                    if (sda_s)
                        state_next = hicd_pkg::ST_IGNORE;
                end
                default:
                begin
                end
            endcase
        end
        else if (fall_c)
        begin
            case (state_reg)
                hicd_pkg::ST_RX:
                begin
                    if (bitcnt_reg == `HICD_BYTE_BITS)
                    begin
                        state_next = hicd_pkg::ST_IGNORE;
                        case (kind_reg)
                            hicd_pkg::K_ADDR:
                            begin
                                if (shreg_reg[7:1] == `HICD_SLAVE_ADDR
                                    && (!shreg_reg[0] || rev_rdy_reg))
                                begin
                                    oe_next    = 1'b1;
                                    state_next = hicd_pkg::ST_ACK;
                                    kind_next  = shreg_reg[0] ? hicd_pkg::K_READ
                                                              : hicd_pkg::K_CMD0;
                                end
                            end
                            hicd_pkg::K_CMD0:
                            begin
                                if (shreg_reg <= `HICD_CMD_ABORT)
                                begin
                                    cmd0_next  = shreg_reg;
                                    oe_next    = 1'b1;
                                    state_next = hicd_pkg::ST_ACK;
                                    kind_next  = hicd_pkg::K_CMD1;
                                end
                            end
                            default:
                            begin
                                if (8'(cmd0_reg + shreg_reg) == 8'h00)
                                begin
                                    wr_ok_next = 1'b1;
                                    oe_next    = 1'b1;
                                    state_next = hicd_pkg::ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                hicd_pkg::ST_ACK:
                begin
                    oe_next     = 1'b0;
                    bitcnt_next = 4'h0;
                    if (kind_reg == hicd_pkg::K_READ)
                    begin
                        txreg_next  = cur_byte;
                        oe_next     = !cur_byte[7];
                        bitcnt_next = 4'h1;
                        state_next  = hicd_pkg::ST_TX;
                    end
                    else if (wr_ok_reg)
                        state_next = hicd_pkg::ST_WAIT_P;
                    else
                        state_next = hicd_pkg::ST_RX;
                end
                hicd_pkg::ST_TX:
                begin
                    if (bitcnt_reg == `HICD_BYTE_BITS)
                    begin
                        oe_next    = 1'b0;
                        state_next = hicd_pkg::ST_MACK;
                        if (rd_idx_reg != 8'(REV_BYTES))
                            rd_idx_next = rd_idx_reg + 8'h01;
                    end
                    else
                    begin
                        txreg_next  = {txreg_reg[6:0], 1'b0};
                        oe_next     = !txreg_reg[6];
                        bitcnt_next = bitcnt_reg + 4'h1;
                    end
                end
                hicd_pkg::ST_WAIT_P:
                begin
                    // Clock low again without Stop or Restart: extra byte
                    oe_next    = 1'b0;
                    state_next = hicd_pkg::ST_IGNORE;
                    wr_ok_next = 1'b0;
                end
                hicd_pkg::ST_MACK:
                begin
                    txreg_next  = cur_byte;
                    oe_next     = !cur_byte[7];
                    bitcnt_next = 4'h1;
                    state_next  = hicd_pkg::ST_TX;
                end
                default:
                begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_bus_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            scl_d_reg   <= 1'b1;
            sda_d_reg   <= 1'b1;
            state_reg   <= hicd_pkg::ST_IDLE;
            kind_reg    <= hicd_pkg::K_ADDR;
            bitcnt_reg  <= 4'h0;
            shreg_reg   <= 8'h00;
            txreg_reg   <= 8'h00;
            cmd0_reg    <= 8'h00;
            rd_idx_reg  <= 8'h00;
            wr_ok_reg   <= 1'b0;
            rev_rdy_reg <= 1'b0;
            oe_reg      <= 1'b0;
            tog_reg     <= 1'b0;
            cmd_reg     <= '0;
        end
        else
        begin
            scl_d_reg   <= scl_s;
            sda_d_reg   <= sda_s;
            state_reg   <= state_next;
            kind_reg    <= kind_next;
            bitcnt_reg  <= bitcnt_next;
            shreg_reg   <= shreg_next;
            txreg_reg   <= txreg_next;
            cmd0_reg    <= cmd0_next;
            rd_idx_reg  <= rd_idx_next;
            wr_ok_reg   <= wr_ok_next;
            rev_rdy_reg <= rev_rdy_next;
            oe_reg      <= oe_next;
            tog_reg     <= tog_next;
            cmd_reg     <= cmd_next;
        end
    end

    assign o_sda_oe = oe_reg;
    assign o_sda    = 1'b0;

    hicd_evt_cross u_evt_cross (
        .i_clk    (i_ref_clk),
        .i_rstn   (i_rstn),
        .i_toggle (tog_reg),
        .o_pulse  (evt_pulse)
    );

    // Effect control in the system clock
    logic       start_reg, start_next;
    logic       abort_reg, abort_next;
    logic [3:0] index_reg, index_next;
    logic       play_reg,  play_next;

    always_comb
    begin
        start_next = evt_pulse && !cmd_reg.abort;
        abort_next = evt_pulse && cmd_reg.abort;
        index_next = start_next ? cmd_reg.index : index_reg;
        if (evt_pulse)
            play_next = !cmd_reg.abort;
        else if (i_effect_done)
            play_next = 1'b0;
        else
            play_next = play_reg;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            index_reg <= 4'h0;
            play_reg  <= 1'b0;
        end
        else
        begin
            start_reg <= start_next;
            abort_reg <= abort_next;
            index_reg <= index_next;
            play_reg  <= play_next;
        end
    end

    assign o_effect_start = start_reg;
    assign o_effect_abort = abort_reg;
    assign o_effect_index = index_reg;
    assign o_playing      = play_reg;

    // Checks
    property p_stop_idle;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        stop_c |=> state_reg == hicd_pkg::ST_IDLE && !oe_reg ##1 !oe_reg;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("not idle after stop");
    property p_bad_addr;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        fall_c && !start_c && !stop_c && state_reg == hicd_pkg::ST_RX
        && kind_reg == hicd_pkg::K_ADDR && bitcnt_reg == `HICD_BYTE_BITS
        && shreg_reg[7:1] != `HICD_SLAVE_ADDR |=> !oe_reg;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("foreign address acked");
    property p_good_addr;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        fall_c && !start_c && !stop_c && state_reg == hicd_pkg::ST_RX
        && kind_reg == hicd_pkg::K_ADDR && bitcnt_reg == `HICD_BYTE_BITS
        && shreg_reg == {`HICD_SLAVE_ADDR, 1'b0} |=> oe_reg && state_reg == hicd_pkg::ST_ACK;
    endproperty
    a_good_addr: assert property (p_good_addr) else $error("own address not acked");
    property p_bad_sum;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        fall_c && !start_c && !stop_c && state_reg == hicd_pkg::ST_RX
        && kind_reg == hicd_pkg::K_CMD1 && bitcnt_reg == `HICD_BYTE_BITS
        && 8'(cmd0_reg + shreg_reg) != 8'h00
        |=> state_reg == hicd_pkg::ST_IGNORE && !wr_ok_reg;
    endproperty
    a_bad_sum: assert property (p_bad_sum) else $error("bad check byte taken");
    property p_undef;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        state_reg == hicd_pkg::ST_IGNORE && !start_c |=> !oe_reg && $stable(tog_reg);
    endproperty
    a_undef: assert property (p_undef) else $error("bus driven while ignoring");
    property p_exec;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        stop_c && state_reg == hicd_pkg::ST_WAIT_P && wr_ok_reg
        && cmd0_reg < `HICD_CMD_REV |=> tog_reg != $past(tog_reg) && !cmd_reg.abort;
    endproperty
    a_exec: assert property (p_exec) else $error("effect not issued at stop");
    property p_start_quiet;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        start_c |=> $stable(tog_reg) && !wr_ok_reg && !oe_reg;
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("restart had effect");
    property p_first_byte;
        @(posedge i_bus_clk) disable iff (!i_rstn)
        fall_c && !start_c && !stop_c && state_reg == hicd_pkg::ST_ACK
        && kind_reg == hicd_pkg::K_READ |=> oe_reg == !txreg_reg[7]
        && txreg_reg == $past(cur_byte);
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("wrong first read bit");
    property p_abort_out;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        evt_pulse && cmd_reg.abort |=> o_effect_abort && !o_playing ##1 !o_effect_abort;
    endproperty
    a_abort_out: assert property (p_abort_out) else $error("abort not applied");
    property p_start_out;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        evt_pulse && !cmd_reg.abort |=> o_effect_start && o_playing
        && o_effect_index == $past(cmd_reg.index);
    endproperty
    a_start_out: assert property (p_start_out) else $error("effect not started");

    c_effect: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_effect_start);
    c_abort:  cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_effect_abort);
    c_read:   cover property (@(posedge i_bus_clk) disable iff (!i_rstn)
                              state_reg == hicd_pkg::ST_MACK);
    c_ignore: cover property (@(posedge i_bus_clk) disable iff (!i_rstn)
                              state_reg == hicd_pkg::ST_IGNORE);
endmodule
`default_nettype wire

// ===== rtl/hicd_regs.svh
// Constants of the haptic command decoder
`ifndef HICD_REGS_SVH
`define HICD_REGS_SVH
`define HICD_SLAVE_ADDR   7'h10
`define HICD_CMD_LAST_FX  8'h0d
`define HICD_CMD_REV      8'h0e
`define HICD_CMD_ABORT    8'h0f
`define HICD_FILL_BYTE    8'hff
`define HICD_BYTE_BITS    4'h8
`define HICD_SYNC_STAGES  2
`endif

// ===== rtl/hicd_pkg.sv
// Types of the haptic command decoder
package hicd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_WAIT_P,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } hicd_state_type;

    typedef enum logic [1:0] {
        K_ADDR,
        K_CMD0,
        K_CMD1,
        K_READ
    } hicd_kind_type;

    typedef struct packed {
        logic       abort;
        logic [3:0] index;
    } hicd_cmd_type;
endpackage

// ===== rtl/hicd_sync.sv
// Two-stage synchroniser for levels
`timescale 1ns/1ns
`default_nettype none
module hicd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule
`default_nettype wire

// ===== rtl/hicd_evt_cross.sv
// Toggle event crossing into the receiving clock
`timescale 1ns/1ns
`default_nettype none
module hicd_evt_cross (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_toggle,
    output logic      o_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic pulse_reg;
    logic pulse_next;

    always_comb
    begin
        pulse_next = sync_reg ^ last_reg;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            last_reg  <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            meta_reg  <= i_toggle;
            sync_reg  <= meta_reg;
            last_reg  <= sync_reg;
            pulse_reg <= pulse_next;
        end
    end

    assign o_pulse = pulse_reg;
endmodule
`default_nettype wire

// ===== bench/hicd_master.sv
// Serial bus master model facing the haptic command decoder
`timescale 1ns/1ns
`default_nettype none
module hicd_master (
    // Bus pins
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // Data bit set while clock low
    task automatic bit_out(input logic b);
        #400 o_sda_low = ~b;
        #400 o_scl = 1'b1;
        #800 o_scl = 1'b0;
    endtask
    // Released bit read mid high
    task automatic bit_in(output logic b);
        #400 o_sda_low = 1'b0;
        #400 o_scl = 1'b1;
        #400 b = i_sda;
        #400 o_scl = 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        #400 o_sda_low = 1'b0;
        #400 o_scl = 1'b1;
        #400 o_sda_low = 1'b1;
        #400 o_scl = 1'b0;
    endtask
    // Stop, clock then stands high
    task automatic stop();
        #400 o_sda_low = 1'b1;
        #400 o_scl = 1'b1;
        #400 o_sda_low = 1'b0;
        #400;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(b);
        ack = ~b;
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(nack);
    endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the haptic command decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [15:0] REV = 16'ha5c3;
    logic       ref_clk     = 1'b0;
    logic       bus_clk     = 1'b0;
    logic       rstn        = 1'b0;
    logic       effect_done = 1'b0;
    logic       scl;
    logic       sda_low;
    logic       sda_oe;
    logic       start;
    logic       abort;
    logic       playing;
    logic [3:0] index;
    logic [3:0] last_idx;
    int         n_start     = 0;
    int         n_abort     = 0;
    int         n_mismatch  = 0;
    int         num_checks  = 0;
    wire logic  sda         = ~(sda_low | sda_oe);

    hicd_top #(.REV_BYTES(2), .REV_DATA(REV)) i_hicd_top (
        .i_ref_clk(ref_clk), .i_bus_clk(bus_clk), .i_rstn(rstn),
        .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
        .i_effect_done(effect_done), .o_effect_start(start),
        .o_effect_abort(abort), .o_effect_index(index), .o_playing(playing));
    hicd_master i_hicd_master (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    always #50 ref_clk = ~ref_clk;
    initial
    begin
        #17;
        forever #40 bus_clk = ~bus_clk;
    end
    always @(posedge ref_clk)
    begin
        if (start === 1'b1)
        begin
            n_start++;
            last_idx = index;
        end
        if (abort === 1'b1)
            n_abort++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (10) @(negedge ref_clk);
    endtask
    task automatic cmd(input logic [7:0] c0, input logic [7:0] c1, input logic [2:0] acks);
        logic [2:0] got;
        i_hicd_master.start();
        i_hicd_master.wr_byte(8'h20, got[2]);
        i_hicd_master.wr_byte(c0, got[1]);
        i_hicd_master.wr_byte(c1, got[0]);
        check({5'h0, got}, {5'h0, acks});
    endtask
    task automatic t_effects();
        int s;
        logic [7:0] c;
        for (int i = 0; i < 14; i++)
        begin
            c = 8'(i);
            s = n_start;
            cmd(c, 8'h00 - c, 3'b111);
            settle();
            check(8'(n_start - s), 8'h00);
            i_hicd_master.stop();
            settle();
            check(8'(n_start - s), 8'h01);
            check({4'h0, last_idx}, c);
            check({7'h0, playing}, 8'h01);
        end
    endtask
    task automatic t_abort_done();
        int a;
        a = n_abort;
        cmd(8'h0f, 8'hf1, 3'b111);
        i_hicd_master.stop();
        settle();
        check(8'(n_abort - a), 8'h01);
        check({7'h0, playing}, 8'h00);
        cmd(8'h02, 8'hfe, 3'b111);
        i_hicd_master.stop();
        settle();
        @(negedge ref_clk) effect_done = 1'b1;
        @(negedge ref_clk) effect_done = 1'b0;
        settle();
        check({7'h0, playing}, 8'h00);
    endtask
    task automatic t_rejects();
        int s;
        int a;
        logic k;
        logic [7:0] bad [3] = '{8'h22, 8'h00, 8'hf0};
        s = n_start;
        a = n_abort;
        cmd(8'h03, 8'h04, 3'b110);
        i_hicd_master.stop();
        cmd(8'h20, 8'he0, 3'b100);
        i_hicd_master.stop();
        cmd(8'h04, 8'hfc, 3'b111);
        i_hicd_master.start();
        i_hicd_master.stop();
        i_hicd_master.start();
        i_hicd_master.wr_byte(8'h20, k);
        i_hicd_master.wr_byte(8'h05, k);
        i_hicd_master.start();
        i_hicd_master.stop();
        i_hicd_master.start();
        i_hicd_master.wr_byte(8'h20, k);
        i_hicd_master.bit_out(1'b0);
        i_hicd_master.bit_out(1'b0);
        i_hicd_master.stop();
        foreach (bad[j])
        begin
            i_hicd_master.start();
            i_hicd_master.wr_byte(bad[j], k);
            check({7'h0, k}, 8'h00);
            i_hicd_master.stop();
        end
        settle();
        check(8'(n_start - s), 8'h00);
        check(8'(n_abort - a), 8'h00);
        check({7'h0, playing}, 8'h00);
        cmd(8'h01, 8'hff, 3'b111);
        i_hicd_master.stop();
        settle();
        check({4'h0, last_idx}, 8'h01);
    endtask
    task automatic t_revision();
        int s;
        logic k;
        logic [7:0] d;
        s = n_start;
        cmd(8'h0e, 8'hf2, 3'b111);
        i_hicd_master.start();
        i_hicd_master.wr_byte(8'h21, k);
        check({7'h0, k}, 8'h01);
        i_hicd_master.rd_byte(1'b0, d);
        check(d, REV[15:8]);
        i_hicd_master.rd_byte(1'b0, d);
        check(d, REV[7:0]);
        i_hicd_master.rd_byte(1'b1, d);
        check(d, 8'hff);
        i_hicd_master.stop();
        settle();
        check(8'(n_start - s), 8'h00);
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #5000000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(posedge bus_clk);
        t_effects();
        t_abort_done();
        t_rejects();
        t_revision();
        complete_run();
    end
endmodule
`default_nettype wire
